// ==== hw/tmcs_core.sv ====
// Functional notes
// - master acts on the bus only while its enable bit is one
// - writing one to state-clear gives a one-cycle state-clear pulse; zero does nothing
// - state-clear pulse empties pending address and data registers
// - ack action is a plain read/write bit, 0 ack, 1 nack, applied on use
// - command field is a write strobe and always reads zero
// - code 0 does nothing; code 1 does ack action then repeated start
// - code 2 reads with ack action, or sends a byte when writing
// - code 3 does ack action then a stop condition
// - one command write updates ack action and command together
// - flags clear as side effect of address, data or command access
// - read-complete set on clean byte read after acknowledged address
// - byte read starts on data read or address write with bit 0 set
// - read, write, stretch and arbitration flags clear on writing one
// - write-complete set at end of any address or byte send
// - completion flags raise read and write interrupts when enabled
// - stretch flag reads one while master holds clock low
// - stretch flag clears on w1, address write, data access, valid command
// - read, write and arbitration flags clear on those same accesses
// - received ack bit is read-only, last ack from slave
// - arbitration-lost set when master loses arbitration
// - after arbitration loss an address write clears the flag
// - address write clears every master flag including bus error, unless bus state is unknown: then write and bus error flags are set
// - bus state reads unknown, idle, owner, busy; writing 1 forces idle
//
// Our own choice: register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
module tmcs_core #(
  parameter int ADR_W = 6
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             wbCyc,
  input  wire logic             wbStb,
  input  wire logic             wbWe,
  input  wire logic [ADR_W-1:0] wbAdr,
  input  wire logic [3:0]       wbSel,
  input  wire logic [31:0]      wbDatIn,
  output logic      [31:0]      wbDatOut,
  output logic                  wbAck,
  input  wire logic             engWriteDone,
  input  wire logic             engReadDone,
  input  wire logic [7:0]       engRxData,
  input  wire logic             engAckIn,
  input  wire logic             engArbLost,
  input  wire logic             engBusErr,
  input  wire logic             engHold,
  input  wire logic [1:0]       engBusState,
  output logic                  masterEn,
  output logic                  flushOut,
  output logic                  cmdStart,
  output logic                  cmdRepStart,
  output logic                  cmdRead,
  output logic                  cmdSend,
  output logic                  cmdStop,
  output logic                  ackSend,
  output logic                  ackLevel,
  output logic                  forceIdle,
  output logic      [7:0]       addrOut,
  output logic      [7:0]       dataOut,
  output logic                  readIrq,
  output logic                  writeIrq
);

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_ADDR = 2'b01,
    PH_XFER = 2'b11,
    PH_STOP = 2'b10
  } tmcs_phase_t;

  typedef struct packed {
    logic        ack;
    logic [7:0]  rdat;
    logic        read_irq_enable;
    logic        write_irq_enable;
    logic        en;
    logic        ackAction;
    logic        readDone;
    logic        writeDone;
    logic        hold;
    logic        received_ack_bit;
    logic        arbitration_lost_flag;
    logic        bus_error_flag;
    logic        addrAcked;
    logic [7:0]  addr;
    logic [7:0]  data;
    tmcs_phase_t phase;
    logic        start;
    logic        repeated_start_code;
    logic        readCmd;
    logic        sendCmd;
    logic        stopCmd;
    logic        ackSend;
    logic        flush;
    logic        forceIdle;
  } tmcs_state_t;

  tmcs_state_t s;
  tmcs_state_t next_s;

  logic       take;
  logic       wr;
  logic       rd;
  logic [3:0] idx;
  logic [7:0] wb;
  logic [1:0] code;
  logic       swClr;
  logic       w1Read;
  logic       w1Write;
  logic       w1Hold;
  logic       w1Arb;
  logic       w1Berr;
  logic       addrWr;
  logic       cleanRead;
  logic [1:0] busShown;
  logic       addrNoBus;

  // sticky flag update, a set in the same cycle beats any clear
  function automatic logic tmcs_sticky(input logic setEv, input logic cur, input logic clrEv);
    return setEv | (cur & ~clrEv);
  endfunction

  // bus decode, byte lane 0 only
  assign take = wbCyc && wbStb && !s.ack;
  assign wr   = take && wbWe && wbSel[0];
  assign rd   = take && !wbWe;
  assign idx  = wbAdr[ADR_W-1:2];
  assign wb   = wbDatIn[7:0];
  assign code = wb[tmcs_pkg::CMD_LSB+:2];
  // disabled master shows unknown bus state
  assign busShown = s.en ? engBusState : tmcs_pkg::BUS_UNKNOWN;

  // next state
  always_comb begin
    next_s           = s;
    next_s.ack       = take;
    next_s.start     = 1'b0;
    next_s.repeated_start_code  = 1'b0;
    next_s.readCmd   = 1'b0;
    next_s.sendCmd   = 1'b0;
    next_s.stopCmd   = 1'b0;
    next_s.ackSend   = 1'b0;
    next_s.flush     = 1'b0;
    next_s.forceIdle = 1'b0;
    swClr            = 1'b0;
    w1Read           = 1'b0;
    w1Write          = 1'b0;
    w1Hold           = 1'b0;
    w1Arb            = 1'b0;
    w1Berr           = 1'b0;
    addrWr           = 1'b0;
    cleanRead        = 1'b0;
    // register reads
    if (rd) begin
      case (idx)
        tmcs_pkg::IDX_CTRL:   next_s.rdat = {s.read_irq_enable, s.write_irq_enable, 5'h00, s.en};
        tmcs_pkg::IDX_CMD:    next_s.rdat = {5'h00, s.ackAction, 2'h0};
        tmcs_pkg::IDX_STATUS: next_s.rdat = {s.readDone, s.writeDone, s.hold, s.received_ack_bit,
                                             s.arbitration_lost_flag, s.bus_error_flag, busShown};
        tmcs_pkg::IDX_ADDR:   next_s.rdat = s.addr;
        tmcs_pkg::IDX_DATA:   next_s.rdat = s.data;
        default:              next_s.rdat = tmcs_pkg::RST_BYTE;
      endcase
    end
    // data read starts next byte read with ack action
    if (rd && idx == tmcs_pkg::IDX_DATA && s.en && s.addr[0]) begin
      swClr          = 1'b1;
      next_s.ackSend = 1'b1;
      next_s.readCmd = 1'b1;
      next_s.phase   = PH_XFER;
    end
    // register writes
    if (wr) begin
      case (idx)
        tmcs_pkg::IDX_CTRL: begin
          next_s.read_irq_enable = wb[tmcs_pkg::CTRL_READ_IRQ_ENABLE];
          next_s.write_irq_enable = wb[tmcs_pkg::CTRL_WRITE_IRQ_ENABLE];
          next_s.en   = wb[tmcs_pkg::CTRL_ENABLE];
        end
        tmcs_pkg::IDX_CMD: begin
          next_s.ackAction = wb[tmcs_pkg::CMD_ACK_ACTION];
          if (wb[tmcs_pkg::CMD_FLUSH]) begin
            next_s.flush = 1'b1;
          end else if (s.en && code != tmcs_pkg::CMD_NO_ACTION_CODE) begin
            swClr = 1'b1;
            case (code)
              tmcs_pkg::CMD_REPEATED_START_CODE: begin
                next_s.ackSend  = 1'b1;
                next_s.repeated_start_code = 1'b1;
                next_s.phase    = PH_ADDR;
              end
              tmcs_pkg::CMD_XFER: begin
                next_s.phase = PH_XFER;
                if (s.addr[0]) begin
                  next_s.ackSend = 1'b1;
                  next_s.readCmd = 1'b1;
                end else begin
                  next_s.sendCmd = 1'b1;
                end
              end
              default: begin
                next_s.ackSend = 1'b1;
                next_s.stopCmd = 1'b1;
                next_s.phase   = PH_STOP;
              end
            endcase
          end
        end
        tmcs_pkg::IDX_STATUS: begin
          w1Read  = wb[tmcs_pkg::ST_READ];
          w1Write = wb[tmcs_pkg::ST_WRITE];
          w1Hold  = wb[tmcs_pkg::ST_HOLD];
          w1Arb   = wb[tmcs_pkg::ST_ARB];
          w1Berr  = wb[tmcs_pkg::ST_BERR];
          next_s.forceIdle = s.en && wb[tmcs_pkg::ST_BUS+:2] == tmcs_pkg::BUS_IDLE;
        end
        tmcs_pkg::IDX_ADDR: begin
          next_s.addr = wb;
          if (s.en) begin
            addrWr           = 1'b1;
            swClr            = 1'b1;
            next_s.addrAcked = 1'b0;
            next_s.phase     = PH_ADDR;
            next_s.start     = engBusState != tmcs_pkg::BUS_UNKNOWN;
          end
        end
        tmcs_pkg::IDX_DATA: begin
          next_s.data = wb;
          if (s.en) begin
            swClr          = 1'b1;
            next_s.sendCmd = 1'b1;
            next_s.phase   = PH_XFER;
          end
        end
        default: begin
        end
      endcase
    end
    // address end tracks slave acknowledge
    if (engWriteDone) begin
      next_s.received_ack_bit = engAckIn;
      if (s.phase == PH_ADDR) begin
        next_s.addrAcked = !engAckIn;
        next_s.phase     = PH_XFER;
      end
    end
    if (engReadDone) begin
      next_s.data = engRxData;
      cleanRead   = s.addrAcked && !s.arbitration_lost_flag && !s.bus_error_flag && !engArbLost && !engBusErr;
    end
    // sticky flags, set wins over clear
    addrNoBus        = addrWr && engBusState == tmcs_pkg::BUS_UNKNOWN;
    next_s.readDone  = tmcs_sticky(cleanRead, s.readDone, swClr | w1Read);
    next_s.writeDone = tmcs_sticky(engWriteDone | addrNoBus, s.writeDone, swClr | w1Write);
    next_s.hold      = tmcs_sticky(engHold, s.hold, swClr | w1Hold);
    next_s.arbitration_lost_flag   = tmcs_sticky(engArbLost, s.arbitration_lost_flag, swClr | w1Arb);
    next_s.bus_error_flag    = tmcs_sticky(engBusErr | addrNoBus, s.bus_error_flag, addrWr | w1Berr);
    // flush or disable empties the master state
    if (next_s.flush || !s.en) begin
      next_s.addr      = tmcs_pkg::RST_BYTE;
      next_s.data      = tmcs_pkg::RST_BYTE;
      next_s.phase     = PH_IDLE;
      next_s.addrAcked = 1'b0;
      next_s.hold      = 1'b0;
      next_s.start     = 1'b0;
      next_s.sendCmd   = 1'b0;
      next_s.readCmd   = 1'b0;
    end
    if (!s.en && wr && idx == tmcs_pkg::IDX_ADDR) begin
      next_s.addr = wb;
    end
  end

  // state register, frozen while ce is low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // outputs straight from state
  assign wbDatOut    = {24'h000000, s.rdat};
  assign wbAck       = s.ack;
  assign masterEn    = s.en;
  assign flushOut    = s.flush;
  assign cmdStart    = s.start;
  assign cmdRepStart = s.repeated_start_code;
  assign cmdRead     = s.readCmd;
  assign cmdSend     = s.sendCmd;
  assign cmdStop     = s.stopCmd;
  assign ackSend     = s.ackSend;
  assign ackLevel    = s.ackAction;
  assign forceIdle   = s.forceIdle;
  assign addrOut     = s.addr;
  assign dataOut     = s.data;
  // interrupt requests from flags and enables
  assign readIrq  = s.readDone & s.read_irq_enable;
  assign writeIrq = s.writeDone & s.write_irq_enable;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_cmd_reads_zero: assert property (wbAck && !wbWe && idx == tmcs_pkg::IDX_CMD |-> wbDatOut[1:0] == 2'h0)
    else $error("command field read nonzero");
  chk_flush_one_cycle: assert property (ce && wr && idx == tmcs_pkg::IDX_CMD && wb[3]
                                        |=> flushOut && addrOut == 8'h00 && dataOut == 8'h00)
    else $error("flush pulse or clear missing");
  chk_flush_zero_idle: assert property (ce && wr && idx == tmcs_pkg::IDX_CMD && !wb[3] |=> !flushOut)
    else $error("flush pulse without request");
  chk_start_needs_en: assert property (ce && (cmdStart || cmdSend || cmdStop) |-> $past(masterEn))
    else $error("command while disabled");
  chk_stop_ack_apply: assert property (ce && masterEn && wr && idx == tmcs_pkg::IDX_CMD && !wb[3]
                                       && wb[1:0] == 2'h3 |=> cmdStop && ackSend && ackLevel == $past(wb[2]))
    else $error("stop without ack action");
  chk_no_action_code_keeps: assert property (ce && masterEn && wr && idx == tmcs_pkg::IDX_CMD && !wb[3]
                                    && wb[1:0] == 2'h0 && !engHold
                                    |=> s.hold == $past(s.hold) && !cmdRepStart && !cmdStop)
    else $error("no-action changed state");
  chk_w1c_read: assert property (ce && wr && idx == tmcs_pkg::IDX_STATUS && wb[7] && !engReadDone
                                 |=> !s.readDone)
    else $error("read flag not cleared");
  chk_set_wins: assert property (ce && engWriteDone && masterEn |=> s.writeDone)
    else $error("write flag lost");
  chk_arb_addr_clear: assert property (ce && masterEn && wr && idx == tmcs_pkg::IDX_ADDR && !engArbLost
                                       && !engReadDone |=> !s.arbitration_lost_flag && !s.readDone)
    else $error("address write left flags");
  chk_bus_ack_drop: assert property (ce && wbAck |=> !wbAck)
    else $error("ack held two cycles");
  chk_bus_answer: assert property (ce && wbCyc && wbStb && !wbAck |=> wbAck)
    else $error("no ack to request");

  // command and access checks
  chk_data_read_go: assert property (ce && masterEn && rd && idx == tmcs_pkg::IDX_DATA && addrOut[0]
                                     |=> cmdRead && ackSend)
    else $error("data read did not start byte read");
  chk_repeated_start_code_ack: assert property (ce && masterEn && wr && idx == tmcs_pkg::IDX_CMD && !wb[3]
                                     && wb[1:0] == 2'h1 |=> cmdRepStart && ackSend && !cmdStop)
    else $error("repeated start without ack action");
  chk_xfer_dir: assert property (ce && masterEn && wr && idx == tmcs_pkg::IDX_CMD && !wb[3]
                                 && wb[1:0] == 2'h2 |=> cmdRead == $past(addrOut[0])
                                 && cmdSend != $past(addrOut[0]) && ackSend == $past(addrOut[0]))
    else $error("byte command ignored direction");
  chk_ack_level: assert property (ce && wr && idx == tmcs_pkg::IDX_CMD |=> ackLevel == $past(wb[2]))
    else $error("ack action not stored");
  chk_force_idle: assert property (ce && masterEn && wr && idx == tmcs_pkg::IDX_STATUS && wb[1:0] == 2'h1
                                   |=> forceIdle)
    else $error("force idle pulse missing");
  chk_off_data_zero: assert property (ce && !masterEn |=> dataOut == 8'h00)
    else $error("disabled master kept data");

  // flag checks
  chk_data_wr_clears: assert property (ce && masterEn && wr && idx == tmcs_pkg::IDX_DATA && !engWriteDone
                                       && !engReadDone && !engHold && !engArbLost
                                       |=> cmdSend && !s.writeDone && !s.readDone && !s.hold && !s.arbitration_lost_flag)
    else $error("data write left flags");
  chk_hold_w1c: assert property (ce && wr && idx == tmcs_pkg::IDX_STATUS && wb[5] && !engHold |=> !s.hold)
    else $error("stretch flag not cleared");
  chk_write_w1c: assert property (ce && wr && idx == tmcs_pkg::IDX_STATUS && wb[6] && !engWriteDone
                                  |=> !s.writeDone)
    else $error("write flag not cleared");
  chk_arb_w1c: assert property (ce && wr && idx == tmcs_pkg::IDX_STATUS && wb[3] && !engArbLost |=> !s.arbitration_lost_flag)
    else $error("arbitration flag not cleared");
  chk_rx_ack_latch: assert property (ce && engWriteDone |=> s.received_ack_bit == $past(engAckIn))
    else $error("received ack not latched");
  chk_read_done_set: assert property (ce && engReadDone && s.addrAcked && !s.arbitration_lost_flag && !s.bus_error_flag
                                      && !engArbLost && !engBusErr |=> s.readDone)
    else $error("read flag not set");

  cov_addr_write: cover property (ce && masterEn && wr && idx == tmcs_pkg::IDX_ADDR ##1 cmdStart);
  cov_stop_cmd: cover property (cmdStop);
  cov_flush: cover property (flushOut);
  cov_read_done: cover property (s.readDone && readIrq);
  cov_rep_start: cover property (cmdRepStart && ackSend);

endmodule
`default_nettype wire

// ==== pkg/tmcs_pkg.sv ====
`default_nettype none
package tmcs_pkg;
  // register indices, byte address is four times the index
  localparam logic [3:0] IDX_CTRL   = 4'h3;
  localparam logic [3:0] IDX_CMD    = 4'h4;
  localparam logic [3:0] IDX_STATUS = 4'h5;
  localparam logic [3:0] IDX_ADDR   = 4'h7;
  localparam logic [3:0] IDX_DATA   = 4'h8;
  // control register fields
  localparam int CTRL_READ_IRQ_ENABLE   = 7;
  localparam int CTRL_WRITE_IRQ_ENABLE   = 6;
  localparam int CTRL_ENABLE = 0;
  // command register fields
  localparam int CMD_FLUSH  = 3;
  localparam int CMD_ACK_ACTION = 2;
  localparam int CMD_LSB    = 0;
  // status register fields
  localparam int ST_READ  = 7;
  localparam int ST_WRITE = 6;
  localparam int ST_HOLD  = 5;
  localparam int ST_RECEIVED_ACK_BIT = 4;
  localparam int ST_ARB   = 3;
  localparam int ST_BERR  = 2;
  localparam int ST_BUS   = 0;
  // command codes
  localparam logic [1:0] CMD_NO_ACTION_CODE    = 2'h0;
  localparam logic [1:0] CMD_REPEATED_START_CODE = 2'h1;
  localparam logic [1:0] CMD_XFER     = 2'h2;
  localparam logic [1:0] CMD_STOP     = 2'h3;
  // bus state codes
  localparam logic [1:0] BUS_UNKNOWN = 2'h0;
  localparam logic [1:0] BUS_IDLE    = 2'h1;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
endpackage
`default_nettype wire

// ==== bench/tmcs_engine_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// behavioural bus engine standing in for the slaves on the wire
module tmcs_engine_model #(
  parameter int DLY = 6
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       masterEn,
  input  wire logic       cmdStart,
  input  wire logic       cmdSend,
  input  wire logic       cmdRead,
  input  wire logic       cmdStop,
  input  wire logic [7:0] addrOut,
  input  wire logic       nackAddr,
  input  wire logic       arbReq,
  input  wire logic [7:0] rxByte,
  output logic            engWriteDone,
  output logic            engReadDone,
  output logic            engAckIn,
  output logic            engArbLost,
  output logic            engHold,
  output logic      [7:0] engRxData,
  output logic      [1:0] engBusState
);
  int         cnt;
  logic [1:0] job;
  // job 1 byte send, 2 address send, 3 byte read; done after DLY cycles
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      job <= 2'h0;
      {engWriteDone, engReadDone, engAckIn, engArbLost, engHold} <= 5'h00;
      engRxData <= 8'h00;
      engBusState <= 2'h0;
    end else begin
      {engWriteDone, engReadDone, engArbLost, engHold} <= 4'h0;
      engRxData <= ~engRxData; // released data never holds its value
      if (cnt > 0) cnt <= cnt - 1;
      if (cmdStart) begin
        job <= 2'h2;
        cnt <= DLY;
      end else if (cmdSend) begin
        job <= 2'h1;
        cnt <= DLY;
      end else if (cmdRead) begin
        job <= 2'h3;
        cnt <= DLY;
      end else if (cnt == 1 && job == 2'h3) begin
        engReadDone <= 1'b1;
        engRxData <= rxByte;
        engHold <= 1'b1;
        job <= 2'h0;
      end else if (cnt == 1) begin
        engWriteDone <= 1'b1;
        engAckIn <= nackAddr;
        engArbLost <= arbReq;
        engHold <= !arbReq;
        // acked read address chains straight into a byte read
        if (job == 2'h2 && addrOut[0] && !nackAddr && !arbReq) begin
          job <= 2'h3;
          cnt <= DLY;
        end else begin
          job <= 2'h0;
        end
      end
      // unknown while disabled, owner after start, idle after stop
      if (!masterEn) engBusState <= 2'h0;
      else if (cmdStart) engBusState <= 2'h2;
      else if (cmdStop || engBusState == 2'h0) engBusState <= 2'h1;
    end
  end
endmodule
`default_nettype wire

// ==== bench/twi_master_command_status_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module twi_master_command_status_tb;
  logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, engBusErr = 1'b0;
  logic        wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
  logic [5:0]  wbAdr = 6'h00;
  logic [3:0]  wbSel = 4'h0;
  logic [31:0] wbDatIn = 32'h0, wbDatOut;
  logic        wbAck, engWriteDone, engReadDone, engAckIn, engArbLost, engHold;
  logic [7:0]  engRxData, addrOut, dataOut, seen = 8'h00, rxByte = 8'h3c;
  logic        seenClr = 1'b0;
  logic [1:0]  engBusState;
  logic        masterEn, flushOut, cmdStart, cmdRepStart, cmdRead, cmdSend, cmdStop;
  logic        ackSend, ackLevel, forceIdle, readIrq, writeIrq, nackAddr = 1'b0, arbReq = 1'b0;
  int          errTotal = 0, checksDone = 0;
  int          ord [4] = '{0, 2, 1, 3};
  logic [7:0]  cmdExp [4] = '{8'h00, 8'h11, 8'h04, 8'h03};

  tmcs_core #(.ADR_W(6)) uut (.*);
  tmcs_engine_model #(.DLY(6)) eng (.*);

  always #10 clk = ~clk;
  // gather core command pulses between checks
  always @(posedge clk) seen <= (seenClr ? 8'h00 : seen)
                                | {flushOut, forceIdle, cmdStart, cmdRepStart, cmdRead, cmdSend, cmdStop, ackSend};

  task automatic finalReport;
    $display("checks %0d mismatches %0d", checksDone, errTotal);
    if (errTotal == 0 && checksDone > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checksDone++;
    if (got !== exp) begin
      errTotal++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // classic single cycle, held until ack is sampled
  task automatic bus(input logic we, input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbSel <= 4'h1;
    wbDatIn <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1);
    q = wbDatOut[7:0];
    chk(8'(n), 8'h02);
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q & m, e);
  endtask
  task automatic clr;
    @(negedge clk);
    seenClr <= 1'b1;
    @(posedge clk);
    seenClr <= 1'b0;
  endtask
  task automatic pul(input logic [7:0] e);
    @(negedge clk);
    chk(seen, e);
  endtask
  task automatic sig(input logic [7:0] s, input logic [7:0] e);
    @(negedge clk);
    chk(s, e);
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // hang guard
  initial begin
    repeat (5000) @(posedge clk);
    errTotal++;
    finalReport;
  end

  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(6'h10, 8'hff, 8'h00);
    rd(6'h14, 8'hff, 8'h00);
    rd(6'h3c, 8'hff, 8'h00);
    clr;
    wr(6'h10, 8'h03);
    pul(8'h00);
    $display("test reset_disabled done");
    wr(6'h0c, 8'hc1);
    sig({7'h0, masterEn}, 8'h01);
    clr;
    wr(6'h1c, 8'ha0);
    pul(8'h20);
    sig(addrOut, 8'ha0);
    waitc(10);
    rd(6'h14, 8'hff, 8'h62);
    sig({6'h0, readIrq, writeIrq}, 8'h01);
    clr;
    wr(6'h20, 8'h5a);
    pul(8'h04);
    sig(dataOut, 8'h5a);
    rd(6'h14, 8'he0, 8'h00);
    waitc(10);
    rd(6'h14, 8'h60, 8'h60);
    $display("test write_transfer done");
    for (int k = 0; k < 4; k++) begin
      clr;
      wr(6'h10, {6'h01, ord[k][1:0]});
      pul(cmdExp[ord[k]]);
      rd(6'h14, 8'h20, (ord[k] == 0) ? 8'h20 : 8'h00);
      rd(6'h10, 8'hff, 8'h04);
      sig({7'h0, ackLevel}, 8'h01);
      waitc(10);
    end
    $display("test commands done");
    wr(6'h10, 8'h00);
    clr;
    wr(6'h1c, 8'ha1);
    pul(8'h20);
    waitc(18);
    rd(6'h14, 8'hf0, 8'he0);
    sig({6'h0, readIrq, writeIrq}, 8'h03);
    clr;
    rd(6'h20, 8'hff, 8'h3c);
    pul(8'h09);
    rd(6'h14, 8'he0, 8'h00);
    waitc(10);
    nackAddr <= 1'b1;
    wr(6'h1c, 8'ha1);
    waitc(10);
    rd(6'h14, 8'hd0, 8'h50);
    nackAddr <= 1'b0;
    $display("test read_transfer done");
    arbReq <= 1'b1;
    wr(6'h1c, 8'ha0);
    waitc(10);
    rd(6'h14, 8'h48, 8'h48);
    wr(6'h14, 8'h08);
    rd(6'h14, 8'h48, 8'h40);
    wr(6'h14, 8'h40);
    rd(6'h14, 8'h48, 8'h00);
    wr(6'h1c, 8'ha0);
    waitc(10);
    arbReq <= 1'b0;
    engBusErr <= 1'b1;
    waitc(1);
    engBusErr <= 1'b0;
    rd(6'h14, 8'h04, 8'h04);
    wr(6'h1c, 8'ha0);
    rd(6'h14, 8'h4c, 8'h00);
    waitc(10);
    $display("test arbitration done");
    clr;
    wr(6'h14, 8'h21);
    pul(8'h40);
    rd(6'h14, 8'h20, 8'h00);
    wr(6'h20, 8'h77);
    waitc(10);
    clr;
    wr(6'h10, 8'h08);
    pul(8'h80);
    sig(addrOut | dataOut, 8'h00);
    clr;
    wr(6'h10, 8'h00);
    pul(8'h00);
    wr(6'h0c, 8'h00);
    rd(6'h14, 8'h03, 8'h00);
    sig({7'h0, masterEn}, 8'h00);
    $display("test flush_disable done");
    finalReport;
  end
endmodule
`default_nettype wire
